// ===== rtl/dup_regs.vh
// constants for the dual uart pin signalling block
// assumes inclusion by bare name from the rtl modules
`ifndef DUP_REGS_VH
`define DUP_REGS_VH
// ------------------------------------------------------------
// data and fifo shape
// ------------------------------------------------------------
`define DUP_DATA_W        8
`define DUP_FIFO_DEPTH    16
`define DUP_FIFO_AW       4
// ------------------------------------------------------------
// serial timing
// ------------------------------------------------------------
`define DUP_CLK_MHZ       200
`define DUP_BAUD_DIV      16'd1736
`define DUP_BIT_CNT_W     16
// ------------------------------------------------------------
// reset values of control pins
// ------------------------------------------------------------
`define DUP_IDLE_LINE     1'b1
`define DUP_RST_OUT2      1'b0
`endif

// ===== rtl/dup_fifo.v
// synchronous fifo with valid and ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module dup_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data,
  // status
  output wire          empty,
  output wire          full
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0]   cnt_ff;
  wire         do_wr;
  wire         do_rd;

  // handshake and status
  assign full      = (cnt_ff == D);
  assign empty     = (cnt_ff == {(AW+1){1'b0}});
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_ptr_ff];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  // storage
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and count
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= (wr_ptr_ff == D-1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= (rd_ptr_ff == D-1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (do_rd & ~do_wr) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ===== rtl/dup_sync.v
// two flip-flop synchroniser for a bus of level inputs
// assumes inputs arrive from outside the clock domain
`timescale 1ns/1ps
module dup_sync #(
  parameter W   = 1,
  parameter RST = 1'b1
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // levels
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage feeds only the second
  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= {W{RST}};
      sync_ff <= {W{RST}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule

// ===== rtl/dup_top.v
// pin signalling of a two-channel serial controller
// assumes one 200 MHz clock, pins pass two flops before use
// Function
// - strobe mode, out2 bit 1: drive channel B irq, general output low.
// - strobe mode, out2 bit 0: float channel B irq, general output high.
// - read/write-line mode: channel B irq pin held low always.
// - each channel gives active-low transmit-ready from its transmit buffer state.
// - each channel gives active-low receive-ready from its receive buffer state.
// - channel A serial data leaves on its transmit pin.
// - active-low request-to-send on channel A only, also usable as general output.
// - active-low clear-to-send on channel A only, also readable as general input.
// - active-low terminal-ready on channel A only, also usable as general output.
// - set-ready, carrier and ring inputs are general inputs only.
// - read/write-line mode: one shared active-low open-drain interrupt.
// - read/write-line mode: second select pin picks channel, low A, high B.
`timescale 1ns/1ps
`include "dup_regs.vh"
module dup_top #(
  parameter W        = `DUP_DATA_W,
  parameter DEPTH    = `DUP_FIFO_DEPTH,
  parameter AW       = `DUP_FIFO_AW,
  parameter BAUD_DIV = `DUP_BAUD_DIV
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // bus mode and select
  input  wire         strobe_mode,
  input  wire         chan_b_select_n,
  // per-channel control bits from the host side
  input  wire [1:0]   out2_ctrl_bit,
  input  wire [1:0]   rts_ctrl,
  input  wire [1:0]   dtr_ctrl,
  input  wire [1:0]   irq_pending,
  // channel A transmit data from host
  input  wire         tx_valid,
  output wire         tx_ready,
  input  wire [W-1:0] tx_data,
  // channel A receive data to host
  output wire         rx_valid,
  input  wire         rx_ready,
  output wire [W-1:0] rx_data,
  // channel B buffer status from its own logic
  input  wire         chan_b_tx_room,
  input  wire         chan_b_rx_avail,
  // channel A serial and modem pins
  output wire         chan_a_serial_out,
  input  wire         chan_a_serial_in,
  output wire         chan_a_req_send_n,
  input  wire         chan_a_clear_send_n,
  output wire         chan_a_term_ready_n,
  input  wire         chan_a_set_ready_n,
  input  wire         chan_a_carrier_n,
  input  wire         chan_a_ring_n,
  // status pins
  output wire         chan_a_tx_ready_n,
  output wire         chan_a_rx_ready_n,
  output wire         chan_b_tx_ready_n,
  output wire         chan_b_rx_ready_n,
  // channel B interrupt and general output
  output wire         chan_b_irq_out,
  output wire         chan_b_irq_oe,
  output wire         chan_b_gp_out2_n,
  // shared open-drain interrupt for read/write-line mode
  output wire         dev_irq_out,
  output wire         dev_irq_oe,
  // channel routing and general inputs seen by the host
  output wire         chan_sel_b,
  output wire [3:0]   chan_a_gp_in
);
  localparam S_IDLE  = 2'd0;
  localparam S_START = 2'd1;
  localparam S_DATA  = 2'd2;
  localparam S_STOP  = 2'd3;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [4:0] pin_q;
  wire       rxd_s;
  wire       cts_n_s;

  dup_sync #(.W(5), .RST(1'b1)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({chan_a_serial_in, chan_a_clear_send_n, chan_a_set_ready_n,
           chan_a_carrier_n, chan_a_ring_n}),
    .q   (pin_q)
  );
  assign rxd_s   = pin_q[4];
  assign cts_n_s = pin_q[3];
  // modem inputs reported; clear-to-send also holds back the transmitter
  assign chan_a_gp_in = pin_q[3:0];

  // ------------------------------------------------------------
  // fifos
  // ------------------------------------------------------------
  wire         txf_valid;
  wire         txf_ready;
  wire [W-1:0] txf_data;
  wire         txf_full;
  wire         rxf_in_valid;
  wire         rxf_in_ready;
  wire         rxf_empty;
  reg  [W-1:0] rx_shift_ff;

  dup_fifo #(.W(W), .D(DEPTH), .AW(AW)) u_txf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (txf_valid),
    .out_ready (txf_ready),
    .out_data  (txf_data),
    .empty     (),
    .full      (txf_full)
  );

  dup_fifo #(.W(W), .D(DEPTH), .AW(AW)) u_rxf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rxf_in_valid),
    .in_ready  (rxf_in_ready),
    .in_data   (rx_shift_ff),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data),
    .empty     (rxf_empty),
    .full      ()
  );

  // ------------------------------------------------------------
  // transmitter, 8N1, held back while clear-to-send is high
  // ------------------------------------------------------------
  reg [1:0]                  tx_st_ff;
  reg [`DUP_BIT_CNT_W-1:0]   tx_div_ff;
  reg [2:0]                  tx_bit_ff;
  reg [W-1:0]                tx_sh_ff;
  reg                        txd_ff;
  wire                       tx_tick;

  assign tx_tick   = (tx_div_ff == BAUD_DIV - 1'b1);
  assign txf_ready = (tx_st_ff == S_IDLE) & ~cts_n_s;

  // bit timing and shifting
  always @(posedge clk) begin
    if (rst) begin
      tx_st_ff  <= S_IDLE;
      tx_div_ff <= {`DUP_BIT_CNT_W{1'b0}};
      tx_bit_ff <= 3'h0;
      tx_sh_ff  <= {W{1'b0}};
      txd_ff    <= `DUP_IDLE_LINE;
    end else begin
      tx_div_ff <= (tx_st_ff == S_IDLE || tx_tick) ? {`DUP_BIT_CNT_W{1'b0}}
                                                   : tx_div_ff + 1'b1;
      case (tx_st_ff)
        S_IDLE: begin
          txd_ff <= `DUP_IDLE_LINE;
          if (txf_valid & txf_ready) begin
            tx_sh_ff <= txf_data;
            txd_ff   <= 1'b0; // start bit
            tx_st_ff <= S_START;
          end
        end
        S_START: begin
          if (tx_tick) begin
            txd_ff    <= tx_sh_ff[0];
            tx_sh_ff  <= tx_sh_ff >> 1;
            tx_bit_ff <= 3'h0;
            tx_st_ff  <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_tick) begin
            if (tx_bit_ff == 3'h7) begin
              txd_ff   <= 1'b1; // stop bit
              tx_st_ff <= S_STOP;
            end else begin
              txd_ff    <= tx_sh_ff[0];
              tx_sh_ff  <= tx_sh_ff >> 1;
              tx_bit_ff <= tx_bit_ff + 1'b1;
            end
          end
        end
        S_STOP: begin
          if (tx_tick) begin
            tx_st_ff <= S_IDLE;
          end
        end
        default: begin
          tx_st_ff <= S_IDLE;
        end
      endcase
    end
  end
  assign chan_a_serial_out = txd_ff;

  // ------------------------------------------------------------
  // receiver, idle line high, mid-bit sampling
  // ------------------------------------------------------------
  reg [1:0]                rx_st_ff;
  reg [`DUP_BIT_CNT_W-1:0] rx_div_ff;
  reg [2:0]                rx_bit_ff;
  reg                      rx_push_ff;
  wire                     rx_tick;
  wire                     rx_half;

  assign rx_tick      = (rx_div_ff == BAUD_DIV - 1'b1);
  assign rx_half      = (rx_div_ff == (BAUD_DIV >> 1));
  assign rxf_in_valid = rx_push_ff; // byte dropped when fifo full

  // low line while idle starts a frame
  always @(posedge clk) begin
    if (rst) begin
      rx_st_ff    <= S_IDLE;
      rx_div_ff   <= {`DUP_BIT_CNT_W{1'b0}};
      rx_bit_ff   <= 3'h0;
      rx_shift_ff <= {W{1'b0}};
      rx_push_ff  <= 1'b0;
    end else begin
      rx_push_ff <= 1'b0;
      rx_div_ff  <= (rx_st_ff == S_IDLE || rx_tick) ? {`DUP_BIT_CNT_W{1'b0}}
                                                    : rx_div_ff + 1'b1;
      case (rx_st_ff)
        S_IDLE: begin
          if (~rxd_s) begin
            rx_st_ff <= S_START;
          end
        end
        S_START: begin
          if (rx_half) begin
            rx_st_ff  <= rxd_s ? S_IDLE : S_DATA; // glitch rejected
            rx_div_ff <= {`DUP_BIT_CNT_W{1'b0}};
            rx_bit_ff <= 3'h0;
          end
        end
        S_DATA: begin
          if (rx_tick) begin
            rx_shift_ff <= {rxd_s, rx_shift_ff[W-1:1]};
            rx_bit_ff   <= rx_bit_ff + 1'b1;
            if (rx_bit_ff == 3'h7) begin
              rx_st_ff <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (rx_tick) begin
            rx_push_ff <= rxd_s & rxf_in_ready; // framing error drops byte
            rx_st_ff   <= S_IDLE;
          end
        end
        default: begin
          rx_st_ff <= S_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // status and modem outputs, registered
  // ------------------------------------------------------------
  reg [3:0] rdy_n_ff;
  reg [1:0] modem_n_ff;
  reg       irq_v_ff;
  reg       irq_oe_ff;
  reg       gp2_n_ff;
  reg       dev_oe_ff;
  reg       sel_b_ff;

  always @(posedge clk) begin
    if (rst) begin
      rdy_n_ff   <= 4'hf;
      modem_n_ff <= 2'h3;
      irq_v_ff   <= 1'b0;
      irq_oe_ff  <= 1'b0;
      gp2_n_ff   <= 1'b1;
      dev_oe_ff  <= 1'b0;
      sel_b_ff   <= 1'b0;
    end else begin
      rdy_n_ff[0] <= txf_full;
      rdy_n_ff[1] <= rxf_empty;
      rdy_n_ff[2] <= ~chan_b_tx_room;
      rdy_n_ff[3] <= ~chan_b_rx_avail;
      modem_n_ff  <= {~dtr_ctrl[0], ~rts_ctrl[0]};
      if (strobe_mode) begin
        irq_v_ff  <= irq_pending[1];
        irq_oe_ff <= out2_ctrl_bit[1];
        gp2_n_ff  <= ~out2_ctrl_bit[1];
        dev_oe_ff <= 1'b0;
        sel_b_ff  <= 1'b0;
      end else begin
        irq_v_ff  <= 1'b0;
        irq_oe_ff <= 1'b1;
        gp2_n_ff  <= 1'b1;
        dev_oe_ff <= |irq_pending;
        sel_b_ff  <= chan_b_select_n;
      end
    end
  end

  assign chan_a_tx_ready_n   = rdy_n_ff[0];
  assign chan_a_rx_ready_n   = rdy_n_ff[1];
  assign chan_b_tx_ready_n   = rdy_n_ff[2];
  assign chan_b_rx_ready_n   = rdy_n_ff[3];
  assign chan_a_req_send_n   = modem_n_ff[0];
  assign chan_a_term_ready_n = modem_n_ff[1];
  assign chan_b_irq_out      = irq_v_ff;
  assign chan_b_irq_oe       = irq_oe_ff;
  assign chan_b_gp_out2_n    = gp2_n_ff;
  assign dev_irq_out         = 1'b0; // open drain pulls low only
  assign dev_irq_oe          = dev_oe_ff;
  assign chan_sel_b          = sel_b_ff;
endmodule

// ===== tb/dup_props.sv
// checker for the pin signalling of the two-channel serial controller
// assumes it is bound to dup_top and sees only its ports
`timescale 1ns/1ps
module dup_props (
  // clock and reset
  input logic       clk,
  input logic       rst,
  // mode, select and control inputs, channel b status, host-side tx ready and rx valid
  input logic       strobe_mode,
  input logic       chan_b_select_n,
  input logic [1:0] out2_ctrl_bit,
  input logic [1:0] irq_pending,
  input logic [1:0] rts_ctrl,
  input logic [1:0] dtr_ctrl,
  input logic       chan_b_tx_room,
  input logic       chan_b_rx_avail,
  input logic       tx_ready,
  input logic       rx_valid,
  // pins driven by the design
  input logic       chan_a_serial_out,
  input logic       chan_a_req_send_n,
  input logic       chan_a_term_ready_n,
  input logic       chan_a_tx_ready_n,
  input logic       chan_a_rx_ready_n,
  input logic       chan_b_tx_ready_n,
  input logic       chan_b_rx_ready_n,
  input logic       chan_b_irq_out,
  input logic       chan_b_irq_oe,
  input logic       chan_b_gp_out2_n,
  input logic       dev_irq_out,
  input logic       dev_irq_oe,
  input logic       chan_sel_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_b_on;
    strobe_mode && out2_ctrl_bit[1] |=> chan_b_irq_oe && !chan_b_gp_out2_n
      && chan_b_irq_out == $past(irq_pending[1]);
  endproperty
  a_b_on: assert property (p_b_on) else $error("channel b irq not driven");
  property p_b_off;
    strobe_mode && !out2_ctrl_bit[1] |=> !chan_b_irq_oe && chan_b_gp_out2_n;
  endproperty
  a_b_off: assert property (p_b_off) else $error("channel b irq not floated");
  property p_rw_low;
    !strobe_mode |=> chan_b_irq_oe && !chan_b_irq_out;
  endproperty
  a_rw_low: assert property (p_rw_low) else $error("channel b irq not held low");
  property p_dev_irq;
    !strobe_mode && (|irq_pending) |=> dev_irq_oe && !dev_irq_out;
  endproperty
  a_dev_irq: assert property (p_dev_irq) else $error("shared irq not pulled low");
  property p_sel;
    !strobe_mode |=> chan_sel_b == $past(chan_b_select_n);
  endproperty
  a_sel: assert property (p_sel) else $error("channel select wrong");
  property p_b_stat;
    1'b1 |=> chan_b_tx_ready_n == !$past(chan_b_tx_room)
      && chan_b_rx_ready_n == !$past(chan_b_rx_avail);
  endproperty
  a_b_stat: assert property (p_b_stat) else $error("channel b status wrong");
  property p_a_stat;
    1'b1 |=> chan_a_tx_ready_n == !$past(tx_ready) && chan_a_rx_ready_n == !$past(rx_valid);
  endproperty
  a_a_stat: assert property (p_a_stat) else $error("channel a status wrong");
  property p_modem;
    1'b1 |=> chan_a_req_send_n == !$past(rts_ctrl[0])
      && chan_a_term_ready_n == !$past(dtr_ctrl[0]);
  endproperty
  a_modem: assert property (p_modem) else $error("modem outputs wrong");
  property p_bit_len;
    $fell(chan_a_serial_out) |-> (!chan_a_serial_out) [*8];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("serial low bit too short");
  // main scenarios reached
  c_irq:  cover property (strobe_mode && out2_ctrl_bit[1] && irq_pending[1]);
  c_selb: cover property (!strobe_mode && chan_b_select_n);
  c_tx:   cover property ($fell(chan_a_serial_out));
  c_full: cover property (!tx_ready);
endmodule

// ===== tb/dup_peer.sv
// serial and modem peer facing channel a
// assumes the device synchronises every pin that this model drives
`timescale 1ns/1ps
module dup_peer #(parameter int DIV = 16) (
  // clock
  input  logic clk,
  // serial lines
  input  logic chan_a_serial_out,
  output logic chan_a_serial_in,
  // modem inputs of the device
  output logic chan_a_clear_send_n,
  output logic chan_a_set_ready_n,
  output logic chan_a_carrier_n,
  output logic chan_a_ring_n
);
  logic [7:0] got_q[$];
  logic [7:0] b;
  // idle line high, modem pins inactive
  initial begin
    chan_a_serial_in = 1'b1;
    {chan_a_clear_send_n, chan_a_set_ready_n, chan_a_carrier_n, chan_a_ring_n} = 4'hf;
  end
  // set modem levels off the sampling edge
  task set_modem(input logic [3:0] v);
    @(negedge clk);
    {chan_a_clear_send_n, chan_a_set_ready_n, chan_a_carrier_n, chan_a_ring_n} = v;
  endtask
  // one frame, lsb first, stop level chosen, line back high after stop
  task send_byte(input logic [7:0] v, input logic stop_lvl);
    @(negedge clk);
    chan_a_serial_in = 1'b0;
    repeat (DIV) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      chan_a_serial_in = v[i];
      repeat (DIV) @(negedge clk);
    end
    chan_a_serial_in = stop_lvl;
    repeat (DIV) @(negedge clk);
    chan_a_serial_in = 1'b1;
    if (!stop_lvl) repeat (DIV) @(negedge clk);
  endtask
  // short low pulse, well under half a bit, then idle high
  task pulse_low(input int n);
    @(negedge clk);
    chan_a_serial_in = 1'b0;
    repeat (n) @(negedge clk);
    chan_a_serial_in = 1'b1;
    repeat (DIV) @(negedge clk);
  endtask
  // decode frames at mid bit, keep those with a good stop bit
  initial forever begin
    @(negedge chan_a_serial_out);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk);
      b[i] = chan_a_serial_out;
    end
    repeat (DIV) @(posedge clk);
    if (chan_a_serial_out === 1'b1) got_q.push_back(b);
  end
endmodule

// ===== tb/tb.sv
// self-checking bench for the pin signalling block
// assumes dup_top, dup_peer and dup_props are compiled before it
`timescale 1ns/1ps
module tb;
  localparam int DIV = 16;
  logic       clk = 1'b0; // no false edge at time zero
  logic       rst, strobe_mode, chan_b_select_n, tx_valid, rx_ready;
  logic       chan_b_tx_room, chan_b_rx_avail;
  logic [1:0] out2_ctrl_bit, rts_ctrl, dtr_ctrl, irq_pending;
  logic [7:0] tx_data;
  wire  [7:0] rx_data;
  wire  [3:0] chan_a_gp_in;
  wire        tx_ready, rx_valid, chan_a_serial_out, chan_a_serial_in, chan_a_req_send_n;
  wire        chan_a_clear_send_n, chan_a_term_ready_n, chan_a_set_ready_n, chan_a_carrier_n;
  wire        chan_a_ring_n, chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n;
  wire        chan_b_rx_ready_n, chan_b_irq_out, chan_b_irq_oe, chan_b_gp_out2_n;
  wire        dev_irq_out, dev_irq_oe, chan_sel_b;
  int         n_fail, checked;
  // design and serial peer
  dup_top #(.BAUD_DIV(16'd16)) i_dup_top (.*);
  dup_peer #(.DIV(DIV)) i_dup_peer (.*);
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // verdict and end of run
  task conclude;
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // value compare
  task compare(input string what, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // push one byte, bounded wait for room
  task push(input logic [7:0] v);
    int k;
    tx_valid = 1'b1;
    tx_data = v;
    k = 0;
    while (tx_ready !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    if (k == 100) begin
      n_fail++;
      conclude();
    end
    cyc(1);
  endtask
  // every bus mode, out2 level and pending combination, select following pending bit 1
  task t_modes;
    logic [5:0] e;
    for (int i = 0; i < 16; i++) begin
      strobe_mode = i[0];
      out2_ctrl_bit = {i[1], ~i[1]};
      irq_pending = i[3:2];
      chan_b_select_n = i[3];
      cyc(2);
      e = i[0] ? {i[3], i[1], ~i[1], 3'b000} : {3'b011, 1'b0, |i[3:2], i[3]};
      compare("irq pins", {chan_b_irq_out, chan_b_irq_oe, chan_b_gp_out2_n, dev_irq_out,
              dev_irq_oe, chan_sel_b}, e);
    end
  endtask
  // channel b status pins follow its buffer state
  task t_bstat;
    for (int j = 0; j < 4; j++) begin
      chan_b_tx_room = j[0];
      chan_b_rx_avail = j[1];
      cyc(2);
      compare("b status", {chan_b_tx_ready_n, chan_b_rx_ready_n}, {~j[0], ~j[1]});
    end
  endtask
  // modem outputs and general inputs
  task t_modem;
    logic [3:0] p[5];
    p = '{4'he, 4'hd, 4'hb, 4'h7, 4'hf};
    for (int j = 0; j < 4; j++) begin
      rts_ctrl = {j[1], j[0]};
      dtr_ctrl = {j[0], j[1]};
      cyc(2);
      compare("modem outs", {chan_a_req_send_n, chan_a_term_ready_n}, {~j[0], ~j[1]});
    end
    for (int j = 0; j < 5; j++) begin
      i_dup_peer.set_modem(p[j]);
      cyc(4);
      compare("general ins", chan_a_gp_in, p[j]);
    end
  endtask
  // fill the transmit buffer while the peer holds off, then drain it
  task t_tx;
    int k;
    for (k = 0; k < 16; k++) push(8'h50 + 8'(k));
    cyc(1);
    compare("tx full pin", chan_a_tx_ready_n, 1'b1);
    tx_data = 8'hee;
    cyc(3);
    tx_valid = 1'b0;
    compare("tx refused", tx_ready, 1'b0);
    i_dup_peer.set_modem(4'h0);
    k = 0;
    while (i_dup_peer.got_q.size() < 16 && k < 4000) begin
      cyc(1);
      k++;
    end
    if (k == 4000) begin
      n_fail++;
      conclude();
    end
    for (k = 0; k < 16; k++) compare("tx byte", i_dup_peer.got_q[k], 8'h50 + 8'(k));
    cyc(2 * DIV);
    compare("tx count", 8'(i_dup_peer.got_q.size()), 8'd16);
    compare("tx idle", {chan_a_serial_out, chan_a_tx_ready_n}, 2'b10);
  endtask
  // overfill the receive buffer, drain it, then a cut frame and a glitch
  task t_rx;
    compare("rx empty pin", chan_a_rx_ready_n, 1'b1);
    for (int k = 0; k < 17; k++) i_dup_peer.send_byte(8'hb0 + 8'(k), 1'b1);
    cyc(3 * DIV);
    compare("rx ready pin", chan_a_rx_ready_n, 1'b0);
    for (int k = 0; k < 16; k++) begin
      compare("rx valid", rx_valid, 1'b1);
      compare("rx byte", rx_data, 8'hb0 + 8'(k));
      rx_ready = 1'b1;
      cyc(1);
    end
    rx_ready = 1'b0;
    compare("rx drained", rx_valid, 1'b0);
    cyc(2);
    compare("rx empty pin", chan_a_rx_ready_n, 1'b1);
    i_dup_peer.send_byte(8'h96, 1'b0);
    i_dup_peer.pulse_low(DIV / 4);
    cyc(3 * DIV);
    compare("rx cut frame", rx_valid, 1'b0);
    i_dup_peer.send_byte(8'h69, 1'b1);
    cyc(3 * DIV);
    compare("rx after cut", {rx_valid, chan_a_rx_ready_n}, 2'b10);
    compare("rx byte", rx_data, 8'h69);
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    strobe_mode = 1'b1;
    chan_b_select_n = 1'b1;
    out2_ctrl_bit = 2'h0;
    rts_ctrl = 2'h0;
    dtr_ctrl = 2'h0;
    irq_pending = 2'h0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b0;
    chan_b_tx_room = 1'b0;
    chan_b_rx_avail = 1'b0;
    n_fail = 0;
    checked = 0;
    cyc(12);
    rst = 1'b0;
    cyc(2);
    t_modes;
    t_bstat;
    t_modem;
    t_tx;
    t_rx;
    conclude();
  end
endmodule
bind dup_top dup_props i_dup_props (.*);
